// [core/lsb_alu_top.sv]
// Logic, shift and byte bit manipulation datapath behind an AXI4-Lite slave
//
// Overview of operation
// RQ1: AND of destination with source or immediate, written back, byte/word/long.
// RQ2: OR of destination with source or immediate, written back, byte/word/long.
// RQ3: XOR of destination with source or immediate, written back, byte/word/long.
// RQ4: Complement replaces the destination with its one's complement, byte/word/long.
// RQ5: Arithmetic shifts by one in place; right shift keeps the sign bit.
// RQ6: Logical shifts by one in place; vacated bit filled with zero.
// RQ7: Plain rotates wrap the outgoing bit into the opposite end.
// RQ8: Rotates via carry insert the carry flag as an extra rotation bit.
// RQ9: Force one selected byte bit to 1; index from immediate or register.
// RQ10: Force one selected byte bit to 0; index from immediate or register.
// RQ11: Toggle one selected byte bit; index from immediate or register.
// RQ12: Probe writes the inverse of the selected bit to zero flag only.
// RQ13: Carry becomes carry AND the selected bit.
// RQ14: Carry becomes carry AND inverted bit; immediate index only.
// RQ15: Carry becomes carry OR the selected bit.
// RQ16: Carry becomes carry OR inverted bit; immediate index only.
// RQ17: Carry becomes carry XOR the selected bit.
// RQ18: Carry becomes carry XOR inverted bit; immediate index only.
// RQ19: Selected bit, or its inverse with immediate index, loads carry.
// RQ20: Carry is written into the selected bit, others unchanged.
// RQ21: Inverted carry is written into the selected bit; immediate index only.
// RQ22: Bit operations act on byte operands, positions 0 to 7.
// RQ23: Logic/shift set N,Z from result; logic clears V; shifts load C.
// RQ24: Bit operations rewrite the whole byte with unchanged bits kept.
`timescale 1ns/1ps
`default_nettype none
`include "lsb_defs.svh"

module lsb_alu_top #(
  parameter int ADDR_W = 8
) (
  input  wire logic              CLK_I,
  input  wire logic              RST_B_I,
  input  wire logic              CE_I,
  input  wire logic [ADDR_W-1:0] AXI_AWADDR_I,
  input  wire logic              AXI_AWVALID_I,
  output logic                   AXI_AWREADY_O,
  input  wire logic [31:0]       AXI_WDATA_I,
  input  wire logic [3:0]        AXI_WSTRB_I,
  input  wire logic              AXI_WVALID_I,
  output logic                   AXI_WREADY_O,
  output logic [1:0]             AXI_BRESP_O,
  output logic                   AXI_BVALID_O,
  input  wire logic              AXI_BREADY_I,
  input  wire logic [ADDR_W-1:0] AXI_ARADDR_I,
  input  wire logic              AXI_ARVALID_I,
  output logic                   AXI_ARREADY_O,
  output logic [31:0]            AXI_RDATA_O,
  output logic [1:0]             AXI_RRESP_O,
  output logic                   AXI_RVALID_O,
  input  wire logic              AXI_RREADY_I
);

  if (ADDR_W < 5 || ADDR_W > 32) begin : g_bad_addr_w
    $error("ADDR_W must lie between 5 and 32");
  end

  function automatic logic [31:0] size_mask(input logic [1:0] sz);
    unique case (sz)
      lsb_pkg::SZ_BYTE: size_mask = 32'h0000_00FF;
      lsb_pkg::SZ_WORD: size_mask = 32'h0000_FFFF;
      default:          size_mask = 32'hFFFF_FFFF;
    endcase
  endfunction

  function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] dat,
                                             input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        old[8*i +: 8] = dat[8*i +: 8];
      end
    end
    strb_merge = old;
  endfunction

  function automatic logic [31:0] word_addr(input logic [ADDR_W-1:0] a);
    word_addr = 32'({a[ADDR_W-1:2], 2'b00});
  endfunction

  // Bus state
  logic              aw_held_r;
  logic              w_held_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0]       wdata_r;
  logic [3:0]        wstrb_r;
  logic              awready_r;
  logic              wready_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic              arready_r;
  logic              rvalid_r;
  logic [31:0]       rdata_r;
  logic [1:0]        rresp_r;

  // Datapath state
  logic [31:0] dst_r;
  logic [31:0] src_r;
  logic [31:0] imm_r;
  logic [3:0]  flags_r;
  logic        err_r;
  logic [7:0]  count_r;

  // Write channel
  wire logic        aw_take     = AXI_AWVALID_I & awready_r;
  wire logic        w_take      = AXI_WVALID_I & wready_r;
  wire logic        wr_go       = aw_held_r & w_held_r & ~bvalid_r;
  wire logic        aw_held_nxt = (aw_held_r | aw_take) & ~wr_go;
  wire logic        w_held_nxt  = (w_held_r | w_take) & ~wr_go;
  wire logic        bvalid_nxt  = (bvalid_r & ~AXI_BREADY_I) | wr_go;
  wire logic [31:0] waddr       = word_addr(awaddr_r);
  wire logic        wsel_cmd    = wr_go & (waddr == `LSB_ADDR_CMD);
  wire logic        wsel_dst    = wr_go & (waddr == `LSB_ADDR_DST);
  wire logic        wsel_src    = wr_go & (waddr == `LSB_ADDR_SRC);
  wire logic        wsel_imm    = wr_go & (waddr == `LSB_ADDR_IMM);
  wire logic        wsel_flg    = wr_go & (waddr == `LSB_ADDR_FLG);
  wire logic        wsel_stat   = wr_go & (waddr == `LSB_ADDR_STAT);
  wire logic        wr_mapped   = wsel_cmd | wsel_dst | wsel_src | wsel_imm | wsel_flg | wsel_stat;

  // Read channel
  wire logic        ar_take    = AXI_ARVALID_I & arready_r;
  wire logic        rvalid_nxt = (rvalid_r & ~AXI_RREADY_I) | ar_take;
  wire logic [31:0] raddr      = word_addr(AXI_ARADDR_I);
  wire logic [31:0] stat_word  = {16'h0000, count_r, 7'h00, err_r};
  wire logic        rd_mapped  = (raddr <= `LSB_ADDR_STAT);
  wire logic [31:0] rd_data    = (raddr == `LSB_ADDR_CMD) ? 32'h0000_0000 :
                                 (raddr == `LSB_ADDR_DST) ? dst_r :
                                 (raddr == `LSB_ADDR_SRC) ? src_r :
                                 (raddr == `LSB_ADDR_IMM) ? imm_r :
                                 (raddr == `LSB_ADDR_FLG) ? {28'h0000000, flags_r} :
                                 (raddr == `LSB_ADDR_STAT) ? stat_word : 32'h0000_0000;

  // Command fields
  wire logic             exec     = wsel_cmd & wstrb_r[0] & wstrb_r[1] & CE_I;
  wire lsb_pkg::lsb_op_e cmd_op   = lsb_pkg::lsb_op_e'(wdata_r[`LSB_CMD_OP_LSB +: 5]);
  wire logic [1:0]       cmd_sz   = wdata_r[`LSB_CMD_SZ_LSB +: 2];
  wire logic             use_imm  = wdata_r[`LSB_CMD_IMMSEL_BIT];
  wire logic             idx_reg  = wdata_r[`LSB_CMD_IDXREG_BIT];
  wire logic [31:0]      opnd_b   = use_imm ? imm_r : src_r;
  wire logic [31:0]      mask     = size_mask(cmd_sz);
  wire logic [31:0]      top      = mask ^ (mask >> 1);
  wire logic [31:0]      dst_m    = dst_r & mask;
  wire logic             dst_msb  = |(dst_r & top);
  wire logic             carry    = flags_r[`LSB_FLG_C];
  wire logic [7:0]       byte_in  = dst_r[7:0];
  wire logic [2:0]       bit_idx  = idx_reg ? src_r[2:0] : wdata_r[`LSB_CMD_IDX_LSB +: 3];
  wire logic             bit_val  = byte_in[bit_idx];
  wire logic [7:0]       bit_oh   = 8'h01 << bit_idx;
  wire logic             inv_op   = (cmd_op == lsb_pkg::OP_CARRY_AND_INV_BIT) |
                                    (cmd_op == lsb_pkg::OP_CARRY_OR_INV_BIT) |
                                    (cmd_op == lsb_pkg::OP_CARRY_XOR_INV_BIT) |
                                    (cmd_op == lsb_pkg::OP_INV_BIT_TO_CARRY) |
                                    (cmd_op == lsb_pkg::OP_INV_CARRY_TO_BIT);

  logic [31:0] sz_val;
  logic        sh_out;
  logic        sz_op;
  logic        sh_op;
  logic [7:0]  byte_new;
  logic        c_new;
  logic        z_new;
  logic        bad_op;

  always_comb begin
    sz_val   = dst_r;
    sh_out   = carry;
    sz_op    = 1'b1;
    sh_op    = 1'b0;
    byte_new = byte_in;
    c_new    = carry;
    z_new    = flags_r[`LSB_FLG_Z];
    bad_op   = 1'b0;
    unique case (cmd_op)
      lsb_pkg::OP_AND: sz_val = dst_r & opnd_b; // [RQ1]
      lsb_pkg::OP_OR:  sz_val = dst_r | opnd_b; // [RQ2]
      lsb_pkg::OP_XOR: sz_val = dst_r ^ opnd_b; // [RQ3]
      lsb_pkg::OP_NOT: sz_val = ~dst_r; // [RQ4]
      lsb_pkg::OP_ARITH_SHIFT_LEFT, lsb_pkg::OP_LOGIC_SHIFT_LEFT: begin
        sz_val = dst_r << 1; // [RQ5] [RQ6]
        sh_out = dst_msb;
        sh_op  = 1'b1;
      end
      lsb_pkg::OP_ARITH_SHIFT_RIGHT: begin
        sz_val = (dst_m >> 1) | (dst_msb ? top : 32'h0000_0000); // [RQ5]
        sh_out = dst_r[0];
        sh_op  = 1'b1;
      end
      lsb_pkg::OP_LOGIC_SHIFT_RIGHT: begin
        sz_val = dst_m >> 1; // [RQ6]
        sh_out = dst_r[0];
        sh_op  = 1'b1;
      end
      lsb_pkg::OP_ROTATE_LEFT: begin
        sz_val = (dst_r << 1) | {31'h00000000, dst_msb}; // [RQ7]
        sh_out = dst_msb;
        sh_op  = 1'b1;
      end
      lsb_pkg::OP_ROTATE_RIGHT: begin
        sz_val = (dst_m >> 1) | (dst_r[0] ? top : 32'h0000_0000); // [RQ7]
        sh_out = dst_r[0];
        sh_op  = 1'b1;
      end
      lsb_pkg::OP_ROTATE_LEFT_VIA_CARRY: begin
        sz_val = (dst_r << 1) | {31'h00000000, carry}; // [RQ8]
        sh_out = dst_msb;
        sh_op  = 1'b1;
      end
      lsb_pkg::OP_ROTATE_RIGHT_VIA_CARRY: begin
        sz_val = (dst_m >> 1) | (carry ? top : 32'h0000_0000); // [RQ8]
        sh_out = dst_r[0];
        sh_op  = 1'b1;
      end
      lsb_pkg::OP_BIT_FORCE_ONE: begin
        sz_op    = 1'b0;
        byte_new = byte_in | bit_oh; // [RQ9] [RQ22]
      end
      lsb_pkg::OP_BIT_FORCE_ZERO: begin
        sz_op    = 1'b0;
        byte_new = byte_in & ~bit_oh; // [RQ10]
      end
      lsb_pkg::OP_BIT_TOGGLE: begin
        sz_op    = 1'b0;
        byte_new = byte_in ^ bit_oh; // [RQ11]
      end
      lsb_pkg::OP_BIT_PROBE: begin
        sz_op = 1'b0;
        z_new = ~bit_val; // [RQ12]
      end
      lsb_pkg::OP_CARRY_AND_BIT: begin
        sz_op = 1'b0;
        c_new = carry & bit_val; // [RQ13]
      end
      lsb_pkg::OP_CARRY_AND_INV_BIT: begin
        sz_op = 1'b0;
        c_new = carry & ~bit_val; // [RQ14]
      end
      lsb_pkg::OP_CARRY_OR_BIT: begin
        sz_op = 1'b0;
        c_new = carry | bit_val; // [RQ15]
      end
      lsb_pkg::OP_CARRY_OR_INV_BIT: begin
        sz_op = 1'b0;
        c_new = carry | ~bit_val; // [RQ16]
      end
      lsb_pkg::OP_CARRY_XOR_BIT: begin
        sz_op = 1'b0;
        c_new = carry ^ bit_val; // [RQ17]
      end
      lsb_pkg::OP_CARRY_XOR_INV_BIT: begin
        sz_op = 1'b0;
        c_new = carry ^ ~bit_val; // [RQ18]
      end
      lsb_pkg::OP_BIT_TO_CARRY: begin
        sz_op = 1'b0;
        c_new = bit_val; // [RQ19]
      end
      lsb_pkg::OP_INV_BIT_TO_CARRY: begin
        sz_op = 1'b0;
        c_new = ~bit_val; // [RQ19]
      end
      lsb_pkg::OP_CARRY_TO_BIT: begin
        sz_op    = 1'b0;
        byte_new = carry ? (byte_in | bit_oh) : (byte_in & ~bit_oh); // [RQ20]
      end
      lsb_pkg::OP_INV_CARRY_TO_BIT: begin
        sz_op    = 1'b0;
        byte_new = carry ? (byte_in & ~bit_oh) : (byte_in | bit_oh); // [RQ21]
      end
      default: begin
        sz_op  = 1'b0;
        bad_op = 1'b1;
      end
    endcase
  end

  // Refused: unknown code, illegal size, inverted op with register index
  wire logic        alu_err = bad_op | (sz_op & (cmd_sz == 2'b11)) |
                              (inv_op & idx_reg); // [RQ14] [RQ16] [RQ18] [RQ19] [RQ21]
  wire logic        exec_ok = exec & ~alu_err;
  wire logic [31:0] res_sz  = sz_val & mask;
  // Bit ops write back the whole byte as read, only the chosen bit altered
  wire logic [31:0] alu_dst = sz_op ? ((dst_r & ~mask) | res_sz)
                                    : {dst_r[31:8], byte_new}; // [RQ24] [RQ22]
  wire logic [3:0]  alu_flg;
  wire logic [31:0] flg_merge = strb_merge({28'h0000000, flags_r}, wdata_r, wstrb_r);
  assign alu_flg[`LSB_FLG_N] = sz_op ? |(res_sz & top) : flags_r[`LSB_FLG_N]; // [RQ23]
  assign alu_flg[`LSB_FLG_Z] = sz_op ? (res_sz == 32'h0000_0000) : z_new; // [RQ23]
  assign alu_flg[`LSB_FLG_V] = sz_op ? 1'b0 : flags_r[`LSB_FLG_V]; // [RQ23]
  assign alu_flg[`LSB_FLG_C] = sh_op ? sh_out : c_new; // [RQ23]

  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      awaddr_r  <= '0;
      wdata_r   <= `LSB_RST_DATA;
      wstrb_r   <= 4'h0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `LSB_RESP_OKAY;
    end else if (CE_I) begin
      aw_held_r <= aw_held_nxt;
      w_held_r  <= w_held_nxt;
      awready_r <= ~aw_held_nxt & ~bvalid_nxt;
      wready_r  <= ~w_held_nxt & ~bvalid_nxt;
      bvalid_r  <= bvalid_nxt;
      if (aw_take) begin
        awaddr_r <= AXI_AWADDR_I;
      end
      if (w_take) begin
        wdata_r <= AXI_WDATA_I;
        wstrb_r <= AXI_WSTRB_I;
      end
      if (wr_go) begin
        bresp_r <= wr_mapped ? `LSB_RESP_OKAY : `LSB_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= `LSB_RST_DATA;
      rresp_r   <= `LSB_RESP_OKAY;
    end else if (CE_I) begin
      arready_r <= ~rvalid_nxt;
      rvalid_r  <= rvalid_nxt;
      if (ar_take) begin
        rdata_r <= rd_data;
        rresp_r <= rd_mapped ? `LSB_RESP_OKAY : `LSB_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      dst_r   <= `LSB_RST_DATA;
      src_r   <= `LSB_RST_DATA;
      imm_r   <= `LSB_RST_DATA;
      flags_r <= `LSB_RST_FLG;
      err_r   <= 1'b0;
      count_r <= `LSB_RST_CNT;
    end else if (CE_I) begin
      if (exec_ok) begin
        dst_r   <= alu_dst; // [RQ1] [RQ5] [RQ9]
        flags_r <= alu_flg;
        count_r <= count_r + 8'h01;
      end else begin
        dst_r   <= wsel_dst ? strb_merge(dst_r, wdata_r, wstrb_r) : dst_r;
        flags_r <= wsel_flg ? flg_merge[3:0] : flags_r;
      end
      if (exec) begin
        err_r <= alu_err;
      end
      if (wsel_src) begin
        src_r <= strb_merge(src_r, wdata_r, wstrb_r);
      end
      if (wsel_imm) begin
        imm_r <= strb_merge(imm_r, wdata_r, wstrb_r);
      end
    end
  end

  assign AXI_AWREADY_O = awready_r;
  assign AXI_WREADY_O  = wready_r;
  assign AXI_BVALID_O  = bvalid_r;
  assign AXI_BRESP_O   = bresp_r;
  assign AXI_ARREADY_O = arready_r;
  assign AXI_RVALID_O  = rvalid_r;
  assign AXI_RDATA_O   = rdata_r;
  assign AXI_RRESP_O   = rresp_r;

  // Previous-cycle copies for the checks below
  logic [31:0] dst_q;
  logic [31:0] src_q;
  logic [31:0] imm_q;
  logic [3:0]  flg_q;
  logic [2:0]  idx_q;
  always_ff @(posedge CLK_I) begin
    dst_q <= dst_r;
    src_q <= src_r;
    imm_q <= imm_r;
    flg_q <= flags_r;
    idx_q <= bit_idx;
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);

  a_and_long_reg: assert property (exec_ok && cmd_op == lsb_pkg::OP_AND && // [RQ1]
      cmd_sz == lsb_pkg::SZ_LONG && !use_imm |=> dst_r == (dst_q & src_q))
    else $error("AND result wrong");
  a_or_long_imm: assert property (exec_ok && cmd_op == lsb_pkg::OP_OR && // [RQ2]
      cmd_sz == lsb_pkg::SZ_LONG && use_imm |=> dst_r == (dst_q | imm_q))
    else $error("OR immediate result wrong");
  a_xor_word_keep: assert property (exec_ok && cmd_op == lsb_pkg::OP_XOR && // [RQ3]
      cmd_sz == lsb_pkg::SZ_WORD && !use_imm |=>
      dst_r == {dst_q[31:16], dst_q[15:0] ^ src_q[15:0]})
    else $error("XOR word result wrong");
  a_not_byte_only: assert property (exec_ok && cmd_op == lsb_pkg::OP_NOT && // [RQ4]
      cmd_sz == lsb_pkg::SZ_BYTE |=> dst_r == (dst_q ^ 32'h0000_00FF))
    else $error("Complement result wrong");
  a_logic_v_zero: assert property (exec_ok && cmd_op <= lsb_pkg::OP_NOT // [RQ23]
      |=> !flags_r[`LSB_FLG_V] && flags_r[`LSB_FLG_C] == flg_q[`LSB_FLG_C])
    else $error("Logic op flag update wrong");
  a_ashr_sign_keep: assert property (exec_ok && // [RQ5]
      cmd_op == lsb_pkg::OP_ARITH_SHIFT_RIGHT && cmd_sz == lsb_pkg::SZ_BYTE |=>
      dst_r[7:0] == {dst_q[7], dst_q[7:1]} && flags_r[`LSB_FLG_C] == dst_q[0])
    else $error("Arithmetic right shift wrong");
  a_lshl_carry_out: assert property (exec_ok && // [RQ6]
      cmd_op == lsb_pkg::OP_LOGIC_SHIFT_LEFT && cmd_sz == lsb_pkg::SZ_LONG |=>
      dst_r == {dst_q[30:0], 1'b0} && flags_r[`LSB_FLG_C] == dst_q[31])
    else $error("Logical left shift wrong");
  a_rot_left_wrap: assert property (exec_ok && // [RQ7]
      cmd_op == lsb_pkg::OP_ROTATE_LEFT && cmd_sz == lsb_pkg::SZ_WORD |=>
      dst_r[15:0] == {dst_q[14:0], dst_q[15]})
    else $error("Rotate left wrong");
  a_rot_carry_in: assert property (exec_ok && // [RQ8]
      cmd_op == lsb_pkg::OP_ROTATE_RIGHT_VIA_CARRY && cmd_sz == lsb_pkg::SZ_LONG |=>
      dst_r == {flg_q[`LSB_FLG_C], dst_q[31:1]} && flags_r[`LSB_FLG_C] == dst_q[0])
    else $error("Rotate via carry wrong");
  a_force_one_bit: assert property (exec_ok && // [RQ9]
      cmd_op == lsb_pkg::OP_BIT_FORCE_ONE |=>
      dst_r == (dst_q | (32'h0000_0001 << idx_q)))
    else $error("Bit force one wrong");
  a_probe_zero_flag: assert property (exec_ok && cmd_op == lsb_pkg::OP_BIT_PROBE // [RQ12]
      |=> flags_r[`LSB_FLG_Z] == !dst_q[idx_q] && dst_r == dst_q)
    else $error("Bit probe wrong");
  a_inv_reg_refused: assert property (exec && inv_op && idx_reg // [RQ14]
      |=> dst_r == dst_q && flags_r == flg_q && err_r)
    else $error("Register index not refused");
  a_store_carry_bit: assert property (exec_ok && cmd_op == lsb_pkg::OP_CARRY_TO_BIT // [RQ20]
      |=> dst_r[idx_q] == flg_q[`LSB_FLG_C] && dst_r[31:8] == dst_q[31:8])
    else $error("Carry store wrong");
  a_write_answer: assert property (wr_go && CE_I |=> AXI_BVALID_O)
    else $error("Write response missing");
  a_read_answer: assert property (ar_take && CE_I |=> AXI_RVALID_O)
    else $error("Read data missing");

  c_rotate_carry: cover property (exec_ok && cmd_op == lsb_pkg::OP_ROTATE_LEFT_VIA_CARRY);
  c_bit_reg_index: cover property (exec_ok && idx_reg && cmd_op == lsb_pkg::OP_BIT_TOGGLE);
  c_refused_cmd: cover property (exec && alu_err);
  c_write_then_read: cover property (wr_go ##1 ar_take);

endmodule // lsb_alu_top

`default_nettype wire

// [inc/lsb_defs.svh]
// Register map, field positions and reset values of the bit ALU
`ifndef LSB_DEFS_SVH
`define LSB_DEFS_SVH

`define LSB_ADDR_CMD        32'h0000_0000
`define LSB_ADDR_DST        32'h0000_0004
`define LSB_ADDR_SRC        32'h0000_0008
`define LSB_ADDR_IMM        32'h0000_000C
`define LSB_ADDR_FLG        32'h0000_0010
`define LSB_ADDR_STAT       32'h0000_0014

`define LSB_CMD_OP_LSB      0
`define LSB_CMD_SZ_LSB      5
`define LSB_CMD_IMMSEL_BIT  7
`define LSB_CMD_IDXREG_BIT  8
`define LSB_CMD_IDX_LSB     9

`define LSB_FLG_C           0
`define LSB_FLG_V           1
`define LSB_FLG_Z           2
`define LSB_FLG_N           3

`define LSB_STAT_ERR_BIT    0
`define LSB_STAT_CNT_LSB    8

`define LSB_RST_DATA        32'h0000_0000
`define LSB_RST_FLG         4'h0
`define LSB_RST_CNT         8'h00

`define LSB_RESP_OKAY       2'h0
`define LSB_RESP_SLVERR     2'h2

`endif

// [inc/lsb_pkg.sv]
// Operation and operand size codes of the bit ALU
package lsb_pkg;

  typedef enum logic [4:0] {
    OP_AND                    = 5'b00000,
    OP_OR                     = 5'b00001,
    OP_XOR                    = 5'b00010,
    OP_NOT                    = 5'b00011,
    OP_ARITH_SHIFT_LEFT       = 5'b00100,
    OP_ARITH_SHIFT_RIGHT      = 5'b00101,
    OP_LOGIC_SHIFT_LEFT       = 5'b00110,
    OP_LOGIC_SHIFT_RIGHT      = 5'b00111,
    OP_ROTATE_LEFT            = 5'b01000,
    OP_ROTATE_RIGHT           = 5'b01001,
    OP_ROTATE_LEFT_VIA_CARRY  = 5'b01010,
    OP_ROTATE_RIGHT_VIA_CARRY = 5'b01011,
    OP_BIT_FORCE_ONE          = 5'b01100,
    OP_BIT_FORCE_ZERO         = 5'b01101,
    OP_BIT_TOGGLE             = 5'b01110,
    OP_BIT_PROBE              = 5'b01111,
    OP_CARRY_AND_BIT          = 5'b10000,
    OP_CARRY_AND_INV_BIT      = 5'b10001,
    OP_CARRY_OR_BIT           = 5'b10010,
    OP_CARRY_OR_INV_BIT       = 5'b10011,
    OP_CARRY_XOR_BIT          = 5'b10100,
    OP_CARRY_XOR_INV_BIT      = 5'b10101,
    OP_BIT_TO_CARRY           = 5'b10110,
    OP_INV_BIT_TO_CARRY       = 5'b10111,
    OP_CARRY_TO_BIT           = 5'b11000,
    OP_INV_CARRY_TO_BIT       = 5'b11001
  } lsb_op_e;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'b00,
    SZ_WORD = 2'b01,
    SZ_LONG = 2'b10
  } lsb_size_e;

endpackage

// [test/lsb_axi_master.sv]
// Register-bus master standing in for the decoder and register file
`timescale 1ns/1ps
`default_nettype none
module lsb_axi_master (
  input  wire logic        clk_i,
  output logic [7:0]       awaddr_o,
  output logic             awvalid_o,
  input  wire logic        awready_i,
  output logic [31:0]      wdata_o,
  output logic [3:0]       wstrb_o,
  output logic             wvalid_o,
  input  wire logic        wready_i,
  input  wire logic [1:0]  bresp_i,
  input  wire logic        bvalid_i,
  output logic             bready_o,
  output logic [7:0]       araddr_o,
  output logic             arvalid_o,
  input  wire logic        arready_i,
  input  wire logic [31:0] rdata_i,
  input  wire logic [1:0]  rresp_i,
  input  wire logic        rvalid_i,
  output logic             rready_o
);
  initial {awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o, bready_o} = '0;
  initial {araddr_o, arvalid_o, rready_o} = '0;
  // Address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    @(posedge clk_i);
    awaddr_o <= a;
    wdata_o <= d;
    wstrb_o <= s;
    awvalid_o <= 1'b1;
    wvalid_o <= 1'b1;
    bready_o <= 1'b1;
    fork
      begin
        do @(posedge clk_i); while (!awready_i);
        awvalid_o <= 1'b0;
      end
      begin
        do @(posedge clk_i); while (!wready_i);
        wvalid_o <= 1'b0;
      end
    join
    do @(posedge clk_i); while (!bvalid_i);
    r = bresp_i;
    bready_o <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_i);
    araddr_o <= a;
    arvalid_o <= 1'b1;
    rready_o <= 1'b1;
    do @(posedge clk_i); while (!arready_i);
    arvalid_o <= 1'b0;
    do @(posedge clk_i); while (!rvalid_i);
    d = rdata_i;
    r = rresp_i;
    rready_o <= 1'b0;
  endtask
endmodule // lsb_axi_master
`default_nettype wire

// [test/logic_shift_bit_alu_test.sv]
// Self-checking bench of the logic, shift and bit datapath
`timescale 1ns/1ps
`default_nettype none
`include "lsb_defs.svh"
module logic_shift_bit_alu_test;
  logic [7:0]  awaddr_o, araddr_o;
  logic [31:0] wdata_o, rdata_i;
  logic [3:0]  wstrb_o;
  logic [1:0]  bresp_i, rresp_i;
  logic        clk, rst_b, awvalid_o, awready_i, wvalid_o, wready_i, bvalid_i, bready_o;
  logic        arvalid_o, arready_i, rvalid_i, rready_o;
  int          n_mismatch, comparisons, cycles, cnt;
  integer      seed = 32'hB577;
  lsb_alu_top lsb_alu_top_i (
    .CLK_I(clk), .RST_B_I(rst_b), .CE_I(1'b1),
    .AXI_AWADDR_I(awaddr_o), .AXI_AWVALID_I(awvalid_o), .AXI_AWREADY_O(awready_i),
    .AXI_WDATA_I(wdata_o), .AXI_WSTRB_I(wstrb_o), .AXI_WVALID_I(wvalid_o),
    .AXI_WREADY_O(wready_i), .AXI_BRESP_O(bresp_i), .AXI_BVALID_O(bvalid_i),
    .AXI_BREADY_I(bready_o), .AXI_ARADDR_I(araddr_o), .AXI_ARVALID_I(arvalid_o),
    .AXI_ARREADY_O(arready_i), .AXI_RDATA_O(rdata_i), .AXI_RRESP_O(rresp_i),
    .AXI_RVALID_O(rvalid_i), .AXI_RREADY_I(rready_o));
  lsb_axi_master lsb_axi_master_i (
    .clk_i(clk), .awaddr_o, .awvalid_o, .awready_i, .wdata_o, .wstrb_o, .wvalid_o,
    .wready_i, .bresp_i, .bvalid_i, .bready_o, .araddr_o, .arvalid_o, .arready_i,
    .rdata_i, .rresp_i, .rvalid_i, .rready_o);
  // Expected {refused, flags, destination}
  function automatic logic [36:0] model(input logic [11:0] cmd,
                                        input logic [31:0] d, s, im, input logic [3:0] fi);
    logic [31:0] m, a, b, r;
    logic [3:0]  f;
    logic [4:0]  op;
    logic [2:0]  i;
    logic        c, bt, v;
    int          w;
    op = cmd[4:0];
    f = fi;
    c = fi[`LSB_FLG_C];
    w = (cmd[6:5] == 2'h0) ? 8 : (cmd[6:5] == 2'h1) ? 16 : 32;
    m = 32'hFFFF_FFFF >> (32 - w);
    a = d & m;
    b = cmd[7] ? im : s;
    i = cmd[8] ? s[2:0] : cmd[11:9];
    bt = d[i];
    v = bt ^ op[0];
    if (op > 25 || (op < 12 && cmd[6:5] == 2'h3) || (op > 16 && op[0] && cmd[8]))
      return {1'b1, fi, d};
    r = d;
    case (op)
      0: r = a & b;
      1: r = a | b;
      2: r = a ^ b;
      3: r = ~a;
      4, 6: {c, r} = {a[w-1], a << 1};
      5: {c, r} = {a[0], (a >> 1) | (a & ~(m >> 1))};
      7: {c, r} = {a[0], a >> 1};
      8: {c, r} = {a[w-1], (a << 1) | 32'(a[w-1])};
      9: {c, r} = {a[0], (a >> 1) | (32'(a[0]) << (w - 1))};
      10: {c, r} = {a[w-1], (a << 1) | 32'(c)};
      11: {c, r} = {a[0], (a >> 1) | (32'(c) << (w - 1))};
      12: r[i] = 1'b1;
      13: r[i] = 1'b0;
      14: r[i] = ~bt;
      15: f[`LSB_FLG_Z] = ~bt;
      16, 17: c = c & v;
      18, 19: c = c | v;
      20, 21: c = c ^ v;
      22, 23: c = v;
      24, 25: r[i] = c ^ op[0];
      default: ;
    endcase
    f[`LSB_FLG_C] = c;
    if (op < 12) begin
      r = (d & ~m) | (r & m);
      f[`LSB_FLG_V] = 1'b0;
      f[`LSB_FLG_Z] = (r & m) == 32'h0;
      f[`LSB_FLG_N] = r[w-1];
    end
    return {1'b0, f, r};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: saw %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [1:0] r;
    lsb_axi_master_i.wr(a[7:0], d, 4'hF, r);
    chk(32'(r), 32'(a > `LSB_ADDR_STAT ? `LSB_RESP_SLVERR : `LSB_RESP_OKAY));
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    logic [1:0] r;
    lsb_axi_master_i.rd(a[7:0], d, r);
    chk(32'(r), 32'(a > `LSB_ADDR_STAT ? `LSB_RESP_SLVERR : `LSB_RESP_OKAY));
  endtask
  task automatic run(input logic [11:0] cmd, input logic [31:0] d, s, im,
                     input logic [3:0] f);
    logic [36:0] e;
    logic [31:0] v;
    e = model(cmd, d, s, im, f);
    cnt = e[36] ? cnt : (cnt + 1) % 256;
    wr(`LSB_ADDR_DST, d);
    wr(`LSB_ADDR_SRC, s);
    wr(`LSB_ADDR_IMM, im);
    wr(`LSB_ADDR_FLG, 32'(f));
    wr(`LSB_ADDR_CMD, 32'(cmd));
    rd(`LSB_ADDR_DST, v);
    chk(v, e[31:0]);
    rd(`LSB_ADDR_FLG, v);
    chk(v, 32'(e[35:32]));
    rd(`LSB_ADDR_STAT, v);
    chk(v, {16'h0, 8'(cnt), 7'h0, e[36]});
  endtask
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_mismatch++;
      test_done();
    end
  end
  initial begin
    logic [31:0] v;
    logic [11:0] cmd;
    logic [1:0]  r;
    rst_b = 1'b0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    for (int a = 0; a <= 24; a += 4) begin
      rd(a, v);
      if (a <= 20) chk(v, 32'h0);
    end
    wr(32'h18, 32'hFFFF_FFFF);
    wr(`LSB_ADDR_STAT, 32'hFFFF_FFFF);
    // Every op at every size, corner data on the second pass, then free random
    for (int k = 0; k < 400; k++) begin
      cmd = 12'($random(seed));
      if (k < 256) cmd[6:0] = k[6:0];
      if (k >= 128 && k < 256) run(cmd, 32'hFF00_8080, 32'h0, 32'h0, 4'($random(seed)));
      else run(cmd, $random(seed), $random(seed), $random(seed), 4'($random(seed)));
    end
    // Partial strobes merge bytes; a command lacking either low strobe is ignored
    wr(`LSB_ADDR_DST, 32'h0);
    lsb_axi_master_i.wr(8'(`LSB_ADDR_DST), 32'hA5A5_A5A5, 4'h5, r);
    chk(32'(r), 32'(`LSB_RESP_OKAY));
    lsb_axi_master_i.wr(8'(`LSB_ADDR_CMD), 32'h0000_0043, 4'h1, r);
    chk(32'(r), 32'(`LSB_RESP_OKAY));
    rd(`LSB_ADDR_DST, v);
    chk(v, 32'h00A5_00A5);
    rd(`LSB_ADDR_STAT, v);
    chk(32'(v[15:8]), 32'(8'(cnt)));
    rd(`LSB_ADDR_CMD, v);
    chk(v, 32'h0);
    test_done();
  end
endmodule // logic_shift_bit_alu_test
`default_nettype wire
